// *** inc/rpm_pkg.sv ***
// Package of the receive performance monitor counter bank.
// Assumes an APB slave with 32-bit data and 16-bit byte addresses.
package rpm_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [15:0] IDX_SEVERE = 16'h0904;
    localparam logic [15:0] IDX_CRC_HI = 16'h0905;
    localparam logic [15:0] IDX_CRC_LO = 16'h0906;
    localparam logic [15:0] IDX_SLIP = 16'h0907;
    localparam logic [15:0] IDX_CTRL = 16'h0910;
    localparam logic [15:0] IDX_IRQ_ST = 16'h0911;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h0912;
    localparam int ADDR_MULT = 4;
    // Control register fields.
    localparam int CTRL_ESF_BIT = 0;
    localparam logic CTRL_ESF_RESET = 1'b0;
    // Interrupt status and mask fields.
    localparam int IRQ_W = 3;
    localparam int IRQ_SEVERE_BIT = 0;
    localparam int IRQ_CRC_BIT = 1;
    localparam int IRQ_SLIP_BIT = 2;
    localparam logic [2:0] IRQ_ST_RESET = 3'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // Counter widths and reset values.
    localparam int CNT8_W = 8;
    localparam int CNT16_W = 16;
    localparam logic [7:0] CNT8_RESET = 8'h00;
    localparam logic [15:0] CNT16_RESET = 16'h0000;
    localparam logic [7:0] CNT8_MAX = 8'hFF;
    localparam logic [15:0] CNT16_MAX = 16'hFFFF;
    // Severely errored frame windows, in microseconds and in superframes.
    localparam int SF_PERIOD_US = 125;
    localparam int SEVERE_SF_TIME_US = 750;
    localparam int SEVERE_ESF_TIME_US = 3000;
    localparam int SEVERE_SF_FRAMES = SEVERE_SF_TIME_US / SF_PERIOD_US;
    localparam int SEVERE_ESF_FRAMES = SEVERE_ESF_TIME_US / SF_PERIOD_US;
    localparam int RUN_W = 5;
    // Receive events from framer and slip buffer, one cycle pulses.
    typedef struct packed {
        logic sf_done;
        logic fbit_err;
        logic crc_err;
        logic slip_repeat;
        logic slip_drop;
    } rpm_evt_t;
endpackage : rpm_pkg

// *** verilog/rpm_top.sv ***
// Receive performance monitor counters with an APB register port.
// Assumes event pulses synchronous to clk_sys and an APB master.
//
// Functional notes
// - Severely errored frame count, eight bits.
// - SF mode: six consecutive errored superframes.
// - ESF mode: twenty-four consecutive errored superframes.
// - Sixteen-bit sync bit error count, two bytes.
// - Ordered upper then lower read clears.
// - Counters reset to zero, clear on read.
// - Slip count, eight bits, since read.
// - Frame repeat or drop is one slip.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module rpm_top (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rpm_pkg::rpm_evt_t rx_evt,
    output logic irq
);
    logic rd_setup;
    logic acc;
    logic rd_acc;
    logic wr_acc;
    logic hit_severe;
    logic hit_hi;
    logic hit_lo;
    logic hit_slip;
    logic hit_ctrl;
    logic hit_st;
    logic hit_mask;
    logic mapped;
    logic esf_q;
    logic [4:0] run_q;
    logic [4:0] limit;
    logic severe_hit;
    logic crc_ev;
    logic slip_ev;
    logic [7:0] severe_cnt_q;
    logic [7:0] severe_cnt_d;
    logic [7:0] slip_cnt_q;
    logic [7:0] slip_cnt_d;
    logic [15:0] crc_cnt_q;
    logic [15:0] crc_cnt_d;
    logic [15:0] snap16_q;
    logic pend_q;
    logic lo_clear;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic [2:0] st_q;
    logic [2:0] st_set;
    logic [2:0] st_clr;
    logic [2:0] mask_q;

    function automatic logic [15:0] idx2addr(input logic [15:0] idx);
        idx2addr = 16'(idx * rpm_pkg::ADDR_MULT);
    endfunction : idx2addr

    // Returns the next value of a saturating counter after a clear-on-read.
    function automatic logic [15:0] cnt_next(input logic [15:0] cur, input logic [15:0] taken,
                                             input logic rd, input logic ev,
                                             input logic [15:0] max);
        logic [15:0] base;
        base = rd ? cur - taken : cur;
        if (ev && base != max) begin
            base = base + 16'h0001;
        end
        cnt_next = base;
    endfunction : cnt_next

    // Address decode and APB phase flags.
    assign rd_setup = psel & ~penable & ~pwrite;
    assign acc = psel & penable;
    assign rd_acc = acc & ~pwrite;
    assign wr_acc = acc & pwrite;
    assign hit_severe = paddr == idx2addr(rpm_pkg::IDX_SEVERE);
    assign hit_hi = paddr == idx2addr(rpm_pkg::IDX_CRC_HI);
    assign hit_lo = paddr == idx2addr(rpm_pkg::IDX_CRC_LO);
    assign hit_slip = paddr == idx2addr(rpm_pkg::IDX_SLIP);
    assign hit_ctrl = paddr == idx2addr(rpm_pkg::IDX_CTRL);
    assign hit_st = paddr == idx2addr(rpm_pkg::IDX_IRQ_ST);
    assign hit_mask = paddr == idx2addr(rpm_pkg::IDX_IRQ_MASK);
    assign mapped = hit_severe | hit_hi | hit_lo | hit_slip | hit_ctrl | hit_st | hit_mask;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_q;

    // Framing mode control register.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            esf_q <= rpm_pkg::CTRL_ESF_RESET;
        end else if (wr_acc && hit_ctrl) begin
            esf_q <= pwdata[rpm_pkg::CTRL_ESF_BIT];
        end
    end

    assign limit = esf_q ? 5'(rpm_pkg::SEVERE_ESF_FRAMES) : 5'(rpm_pkg::SEVERE_SF_FRAMES);
    assign severe_hit = rx_evt.sf_done & rx_evt.fbit_err & (run_q == limit - 5'h01);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_q <= 5'h00;
        end else if (wr_acc && hit_ctrl) begin
            run_q <= 5'h00;
        end else if (rx_evt.sf_done) begin
            if (!rx_evt.fbit_err || severe_hit) begin
                run_q <= 5'h00;
            end else begin
                run_q <= run_q + 5'h01;
            end
        end
    end

    assign slip_ev = rx_evt.slip_repeat | rx_evt.slip_drop;
    assign crc_ev = rx_evt.crc_err;
    assign lo_clear = rd_acc & hit_lo & pend_q;

    assign severe_cnt_d = 8'(cnt_next({8'h00, severe_cnt_q}, {8'h00, prdata_q[7:0]},
        rd_acc & hit_severe, severe_hit, {8'h00, rpm_pkg::CNT8_MAX}));
    assign slip_cnt_d = 8'(cnt_next({8'h00, slip_cnt_q}, {8'h00, prdata_q[7:0]},
                                    rd_acc & hit_slip, slip_ev, {8'h00, rpm_pkg::CNT8_MAX}));
    assign crc_cnt_d = cnt_next(crc_cnt_q, snap16_q, lo_clear, crc_ev, rpm_pkg::CNT16_MAX);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            severe_cnt_q <= rpm_pkg::CNT8_RESET;
            slip_cnt_q <= rpm_pkg::CNT8_RESET;
            crc_cnt_q <= rpm_pkg::CNT16_RESET;
        end else begin
            severe_cnt_q <= severe_cnt_d;
            slip_cnt_q <= slip_cnt_d;
            crc_cnt_q <= crc_cnt_d;
        end
    end

    // upper read snapshots the whole count.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            snap16_q <= rpm_pkg::CNT16_RESET;
        end else if (rd_setup && hit_hi) begin
            snap16_q <= crc_cnt_q;
        end
    end

    // pair tracking from upper read to lower read.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
        end else if (rd_acc && hit_hi) begin
            pend_q <= 1'b1;
        end else if (rd_acc && hit_lo) begin
            pend_q <= 1'b0;
        end
    end

    // Read data is chosen in the setup cycle and held through access.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_severe: rd_mux[7:0] = severe_cnt_q;
            hit_hi: rd_mux[7:0] = crc_cnt_q[15:8];
            hit_lo: rd_mux[7:0] = pend_q ? snap16_q[7:0] : crc_cnt_q[7:0];
            hit_slip: rd_mux[7:0] = slip_cnt_q;
            hit_ctrl: rd_mux[rpm_pkg::CTRL_ESF_BIT] = esf_q;
            hit_st: rd_mux[2:0] = st_q;
            hit_mask: rd_mux[2:0] = mask_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    // Sticky event status, write one to clear, set wins.
    always_comb begin
        st_set = 3'h0;
        st_set[rpm_pkg::IRQ_SEVERE_BIT] = severe_hit;
        st_set[rpm_pkg::IRQ_CRC_BIT] = crc_ev;
        st_set[rpm_pkg::IRQ_SLIP_BIT] = slip_ev;
        st_clr = (wr_acc && hit_st) ? pwdata[rpm_pkg::IRQ_W-1:0] : 3'h0;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= rpm_pkg::IRQ_ST_RESET;
        end else begin
            st_q <= (st_q & ~st_clr) | st_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_q <= rpm_pkg::IRQ_MASK_RESET;
        end else if (wr_acc && hit_mask) begin
            mask_q <= pwdata[rpm_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(st_q & mask_q);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    severe_count_a: assert property (
        severe_hit && !(rd_acc && hit_severe) && severe_cnt_q != rpm_pkg::CNT8_MAX
        |=> severe_cnt_q == $past(severe_cnt_q) + 8'h01)
        else $error("Severe frame counter did not step on a severely errored frame.");

    sf_window_a: assert property (
        !esf_q && rx_evt.sf_done && rx_evt.fbit_err && run_q == 5'h05 |-> severe_hit)
        else $error("SF window of six errored superframes not declared.");

    esf_window_a: assert property (
        esf_q && rx_evt.sf_done && rx_evt.fbit_err && run_q == 5'h17 |-> severe_hit)
        else $error("ESF window of twenty-four errored superframes not declared.");

    crc_count_a: assert property (
        crc_ev && !lo_clear && crc_cnt_q != rpm_pkg::CNT16_MAX
        |=> crc_cnt_q == $past(crc_cnt_q) + 16'h0001)
        else $error("Sync bit error counter did not step.");

    pair_clear_a: assert property (
        lo_clear && !crc_ev |=> crc_cnt_q == $past(crc_cnt_q) - $past(snap16_q))
        else $error("Ordered pair read did not clear the sync count.");

    slip_clear_a: assert property (
        rd_acc && hit_slip && !slip_ev |=> slip_cnt_q == $past(slip_cnt_q) - $past(prdata_q[7:0]))
        else $error("Slip counter not cleared by its read.");

    slip_count_a: assert property (
        slip_ev && !(rd_acc && hit_slip) && slip_cnt_q != rpm_pkg::CNT8_MAX
        |=> slip_cnt_q == $past(slip_cnt_q) + 8'h01)
        else $error("Slip counter did not step on a slip.");

    held_lower_a: assert property (
        rd_setup && hit_lo && pend_q |=> prdata_q[7:0] == $past(snap16_q[7:0]))
        else $error("Lower byte read did not return the captured value.");

    severe_sat_a: assert property (
        severe_cnt_q == rpm_pkg::CNT8_MAX && !(rd_acc && hit_severe)
        |=> severe_cnt_q == rpm_pkg::CNT8_MAX)
        else $error("Severe frame counter wrapped past all ones.");

    severe_hold_a: assert property (
        !severe_hit && !(rd_acc && hit_severe) |=> $stable(severe_cnt_q))
        else $error("Severe frame counter moved without an event or a read.");

    severe_clear_a: assert property (
        rd_acc && hit_severe && !severe_hit
        |=> severe_cnt_q == $past(severe_cnt_q) - $past(prdata_q[7:0]))
        else $error("Severe frame counter not cleared by its read.");

    run_step_a: assert property (
        rx_evt.sf_done && rx_evt.fbit_err && !severe_hit && !(wr_acc && hit_ctrl)
        |=> run_q == $past(run_q) + 5'h01)
        else $error("Errored superframe run did not advance.");

    run_break_a: assert property (
        rx_evt.sf_done && !rx_evt.fbit_err |=> run_q == 5'h00)
        else $error("Errored superframe run not restarted by a clean superframe.");

    crc_hold_a: assert property (
        !crc_ev && !lo_clear |=> $stable(crc_cnt_q))
        else $error("Sync bit error counter moved without an event or a read.");

    upper_keep_a: assert property (
        rd_acc && hit_hi && !crc_ev |=> $stable(crc_cnt_q))
        else $error("Upper byte read changed the sync count.");

    lower_keep_a: assert property (
        rd_acc && hit_lo && !pend_q && !crc_ev |=> $stable(crc_cnt_q))
        else $error("Unpaired lower byte read changed the sync count.");

    snap_take_a: assert property (
        rd_setup && hit_hi |=> snap16_q == $past(crc_cnt_q))
        else $error("Upper byte read did not capture the whole sync count.");

    slip_once_a: assert property (
        rx_evt.slip_repeat && rx_evt.slip_drop && !(rd_acc && hit_slip)
        && slip_cnt_q != rpm_pkg::CNT8_MAX |=> slip_cnt_q == $past(slip_cnt_q) + 8'h01)
        else $error("Repeat and drop in one cycle did not count once.");

    crc_sat_a: assert property (
        crc_cnt_q == rpm_pkg::CNT16_MAX && !lo_clear |=> crc_cnt_q == rpm_pkg::CNT16_MAX)
        else $error("Sync bit error counter wrapped past all ones.");

    slip_sat_a: assert property (
        slip_cnt_q == rpm_pkg::CNT8_MAX && !(rd_acc && hit_slip)
        |=> slip_cnt_q == rpm_pkg::CNT8_MAX)
        else $error("Slip counter wrapped past all ones.");

    // Event status set wins over clear.
    status_set_a: assert property (
        st_set != 3'h0 |=> (st_q & $past(st_set)) == $past(st_set))
        else $error("Event status bit not set by its event.");

    // Unmapped writes are dropped.
    bad_write_a: assert property (
        wr_acc && !mapped |=> mask_q == $past(mask_q) && esf_q == $past(esf_q))
        else $error("Write to an unmapped address changed a register.");

    // Read data stands until the next read setup.
    rdata_hold_a: assert property (
        !rd_setup |=> $stable(prdata_q))
        else $error("Read data changed outside a read setup cycle.");

    severe_seen_c: cover property (severe_hit ##[1:40] (rd_acc && hit_severe));
    pair_read_c: cover property ((rd_acc && hit_hi) ##[1:20] lo_clear);
    slip_sat_c: cover property (slip_cnt_q == rpm_pkg::CNT8_MAX && slip_ev);
    esf_declare_c: cover property (esf_q && severe_hit);
    lower_alone_c: cover property (rd_acc && hit_lo && !pend_q);
endmodule : rpm_top

// *** tb/rpm_top_bench.sv ***
// Self-checking bench of the receive performance monitor counter bank.
// Assumes rpm_top with a zero-wait APB port and one-cycle event pulses.
`timescale 1ns/100ps
module rpm_top_bench;
    logic clk_sys;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic pready;
    logic pslverr;
    logic irq;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    rpm_pkg::rpm_evt_t rx_evt;
    int error_cnt;
    int check_count;
    logic [15:0] regs [7] = '{rpm_pkg::IDX_SEVERE, rpm_pkg::IDX_CRC_HI, rpm_pkg::IDX_CRC_LO,
        rpm_pkg::IDX_SLIP, rpm_pkg::IDX_CTRL, rpm_pkg::IDX_IRQ_ST, rpm_pkg::IDX_IRQ_MASK};

    rpm_top uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_evt(rx_evt), .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer: setup, then access held until pready is seen high.
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : xfer

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic eerr);
        logic [31:0] d;
        logic e;
        xfer(1'b0, idx, 32'h0, d, e);
        check(d, exp);
        check({31'h0, e}, {31'h0, eerr});
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        xfer(1'b1, idx, wd, d, e);
    endtask : wr

    task automatic evt(input logic [4:0] e, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            rx_evt <= rpm_pkg::rpm_evt_t'(e);
        end
        @(posedge clk_sys);
        rx_evt <= '0;
    endtask : evt

    task automatic irq_is(input logic exp);
        @(negedge clk_sys);
        check({31'h0, irq}, {31'h0, exp});
    endtask : irq_is

    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        rx_evt = '0;
        error_cnt = 0;
        check_count = 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(regs[i], 32'h0, 1'b0);
        end
        evt(5'h02, 3);
        evt(5'h01, 2);
        evt(5'h03, 1);
        rd(rpm_pkg::IDX_SLIP, 32'h06, 1'b0);
        rd(rpm_pkg::IDX_SLIP, 32'h00, 1'b0);
        evt(5'h04, 300);
        rd(rpm_pkg::IDX_CRC_HI, 32'h01, 1'b0);
        evt(5'h04, 5);
        rd(rpm_pkg::IDX_CRC_LO, 32'h2C, 1'b0);
        rd(rpm_pkg::IDX_CRC_LO, 32'h05, 1'b0);
        rd(rpm_pkg::IDX_CRC_LO, 32'h05, 1'b0);
        rd(rpm_pkg::IDX_CRC_HI, 32'h00, 1'b0);
        rd(rpm_pkg::IDX_CRC_LO, 32'h05, 1'b0);
        rd(rpm_pkg::IDX_CRC_HI, 32'h00, 1'b0);
        rd(rpm_pkg::IDX_CRC_LO, 32'h00, 1'b0);
        evt(5'h18, 5);
        evt(5'h10, 1);
        evt(5'h18, 5);
        rd(rpm_pkg::IDX_SEVERE, 32'h00, 1'b0);
        evt(5'h18, 1);
        rd(rpm_pkg::IDX_SEVERE, 32'h01, 1'b0);
        evt(5'h18, 3);
        wr(rpm_pkg::IDX_CTRL, 32'h1);
        rd(rpm_pkg::IDX_CTRL, 32'h1, 1'b0);
        evt(5'h18, 23);
        rd(rpm_pkg::IDX_SEVERE, 32'h00, 1'b0);
        evt(5'h18, 1);
        rd(rpm_pkg::IDX_SEVERE, 32'h01, 1'b0);
        rd(rpm_pkg::IDX_IRQ_ST, 32'h7, 1'b0);
        irq_is(1'b0);
        wr(rpm_pkg::IDX_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(rpm_pkg::IDX_IRQ_ST, 32'h1);
        rd(rpm_pkg::IDX_IRQ_ST, 32'h6, 1'b0);
        irq_is(1'b0);
        wr(rpm_pkg::IDX_IRQ_MASK, 32'h7);
        irq_is(1'b1);
        wr(rpm_pkg::IDX_IRQ_ST, 32'h6);
        irq_is(1'b0);
        evt(5'h02, 260);
        rd(rpm_pkg::IDX_SLIP, 32'hFF, 1'b0);
        wr(rpm_pkg::IDX_SLIP, 32'h55);
        rd(rpm_pkg::IDX_SLIP, 32'h00, 1'b0);
        rd(16'h0908, 32'h0, 1'b1);
        report_and_stop();
    end
endmodule : rpm_top_bench
